// >>> emi_defines.svh
// Offsets, field positions, reset values and pin positions of the external memory interface
`ifndef EMI_DEFINES_SVH
`define EMI_DEFINES_SVH

`define EMI_MCU_CTRL_IDX     8'h35
`define EMI_EXT_CTRL_IDX     8'h36
`define EMI_MCU_CTRL_RST     8'h00
`define EMI_EXT_CTRL_RST     8'h00

`define EMI_EN_BIT           7
`define EMI_UPPER_LO_BIT     6
`define EMI_UPPER_HI_BIT     1
`define EMI_LOWER_HI_BIT     3
`define EMI_LOWER_LO_BIT     2
`define EMI_LIMIT_MSB        6
`define EMI_LIMIT_LSB        4

`define EMI_EXT_BASE         16'h0460
`define EMI_PAGE_SHIFT       13

`define EMI_WR_PIN           6
`define EMI_RD_PIN           7
`define EMI_ALE_PIN          1

`endif

// >>> emi_pkg.sv
// Types shared by the external memory interface files
package emi_pkg;

  typedef enum logic [4:0] {
    EMI_IDLE = 5'b00001,
    EMI_ALE  = 5'b00010,
    EMI_STRB = 5'b00100,
    EMI_GAP  = 5'b01000,
    EMI_END  = 5'b10000
  } emi_state_t;

  typedef logic [1:0] emi_wait_t;
  typedef logic [7:0] emi_byte_t;
  typedef logic [15:0] emi_addr_t;

endpackage

// >>> emi_wait_cnt.sv
// Strobe length counter for wait states
`timescale 1ns/100ps
module emi_wait_cnt (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire emi_pkg::emi_wait_t i_value,
  output logic                  o_last
);
  import emi_pkg::*;

  emi_wait_t cnt;
  emi_wait_t next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (i_load) begin
      next_cnt = i_value;
    end else if (cnt != 2'h0) begin
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 2'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_last = (cnt == 2'h0);
endmodule

// >>> emi_top.sv
// External data memory interface: APB control registers, page/wait logic, bus sequencer, pin override
//
// Summary of operation
// - Enable bit gives pins their memory functions
// - Enable low restores normal pin values, directions
// - Enable low: no fold onto internal SRAM
// - Low address/data multiplexed; high address separate
// - Limit zero: one page 0460-FFFF, upper waits
// - Limits 1-7 start upper page 2000..E000
// - Upper wait select split across two registers
// - Lower wait select in extended bits 3:2
// - Waits: none, +1, +2, +2 plus gap
// - Final period: ALE, address change only if RAM next
// - Valid address at ALE fall; ALE low during transfer
// - Strobes only for external memory accesses
// - High address stable throughout every external access
`timescale 1ns/100ps
`include "emi_defines.svh"
module emi_top (
  input  wire logic               i_mclk,
  input  wire logic               i_rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               i_req,
  input  wire logic               i_we,
  input  wire emi_pkg::emi_addr_t i_addr,
  input  wire emi_pkg::emi_byte_t i_wdata,
  input  wire logic               i_next_ram,
  input  wire emi_pkg::emi_addr_t i_next_addr,
  output logic                    o_ready,
  output logic                    o_done,
  output logic                    o_unmapped,
  output emi_pkg::emi_byte_t      o_rdata,
  input  wire emi_pkg::emi_byte_t i_gpio_a_out,
  input  wire emi_pkg::emi_byte_t i_port_a_direction,
  input  wire emi_pkg::emi_byte_t i_gpio_c_out,
  input  wire emi_pkg::emi_byte_t i_port_c_direction,
  input  wire emi_pkg::emi_byte_t i_gpio_d_out,
  input  wire emi_pkg::emi_byte_t i_port_d_direction,
  input  wire emi_pkg::emi_byte_t i_gpio_e_out,
  input  wire emi_pkg::emi_byte_t i_port_e_direction,
  input  wire emi_pkg::emi_byte_t i_pa_in,
  output emi_pkg::emi_byte_t      o_pa_out,
  output emi_pkg::emi_byte_t      o_pa_oe,
  output emi_pkg::emi_byte_t      o_pc_out,
  output emi_pkg::emi_byte_t      o_pc_oe,
  output emi_pkg::emi_byte_t      o_pd_out,
  output emi_pkg::emi_byte_t      o_pd_oe,
  output emi_pkg::emi_byte_t      o_pe_out,
  output emi_pkg::emi_byte_t      o_pe_oe
);
  import emi_pkg::*;

  // Register file
  emi_byte_t  mcu_control;
  emi_byte_t  extended_mcu_control;
  emi_byte_t  next_mcu_control;
  emi_byte_t  next_extended_mcu_control;
  logic [31:0] next_prdata;
  logic       next_pready;
  logic       next_pslverr;
  logic       hit_mcu;
  logic       hit_ext;

  assign hit_mcu = (paddr[11:2] == {2'h0, `EMI_MCU_CTRL_IDX}) && (paddr[1:0] == 2'h0);
  assign hit_ext = (paddr[11:2] == {2'h0, `EMI_EXT_CTRL_IDX}) && (paddr[1:0] == 2'h0);

  always_comb begin
    next_mcu_control          = mcu_control;
    next_extended_mcu_control = extended_mcu_control;
    next_prdata               = prdata;
    next_pready               = 1'b0;
    next_pslverr              = 1'b0;
    if (psel && !penable) begin
      next_pready  = 1'b1;
      next_pslverr = !(hit_mcu || hit_ext);
      next_prdata  = 32'h0000_0000;
      if (hit_mcu) begin
        next_prdata = {24'h00_0000, mcu_control};
      end else if (hit_ext) begin
        next_prdata = {24'h00_0000, extended_mcu_control};
      end
    end
    if (psel && penable && pready && pwrite) begin
      if (hit_mcu) begin
        next_mcu_control = pwdata[7:0];
      end
      if (hit_ext) begin
        next_extended_mcu_control = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mcu_control          <= `EMI_MCU_CTRL_RST;
      extended_mcu_control <= `EMI_EXT_CTRL_RST;
      prdata               <= 32'h0000_0000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else begin
      mcu_control          <= next_mcu_control;
      extended_mcu_control <= next_extended_mcu_control;
      prdata               <= next_prdata;
      pready               <= next_pready;
      pslverr              <= next_pslverr;
    end
  end

  // Control fields
  logic       ext_mem_enable;
  logic [2:0] page_limit;
  emi_wait_t  upper_wait;
  emi_wait_t  lower_wait;
  emi_addr_t  upper_start;
  emi_wait_t  req_wait;
  logic       req_ext;
  emi_wait_t  req_extra;

  assign ext_mem_enable = mcu_control[`EMI_EN_BIT];
  assign page_limit = extended_mcu_control[`EMI_LIMIT_MSB:`EMI_LIMIT_LSB];
  assign upper_wait = {extended_mcu_control[`EMI_UPPER_HI_BIT], mcu_control[`EMI_UPPER_LO_BIT]};
  assign lower_wait = {extended_mcu_control[`EMI_LOWER_HI_BIT],
                       extended_mcu_control[`EMI_LOWER_LO_BIT]};
  // Upper page starts at limit times 8 KB; zero means one page, upper waits
  assign upper_start = (page_limit == 3'h0) ? `EMI_EXT_BASE :
                       emi_addr_t'({page_limit, 13'h0000});
  assign req_ext   = (i_addr >= `EMI_EXT_BASE);
  assign req_wait  = (i_addr >= upper_start) ? upper_wait : lower_wait;
  assign req_extra = (req_wait == 2'h0) ? 2'h0 : ((req_wait == 2'h1) ? 2'h1 : 2'h2);

  // Bus sequencer
  emi_state_t state;
  emi_state_t next_state;
  emi_addr_t  bus_addr;
  emi_addr_t  next_bus_addr;
  logic       we_q;
  logic       next_we_q;
  emi_byte_t  wdata_q;
  emi_byte_t  next_wdata_q;
  logic       gap_q;
  logic       next_gap_q;
  logic       ale;
  logic       next_ale;
  logic       rd_n;
  logic       next_rd_n;
  logic       wr_n;
  logic       next_wr_n;
  logic       lo_drive;
  logic       next_lo_drive;
  emi_byte_t  lo_val;
  emi_byte_t  next_lo_val;
  logic       next_ready;
  logic       next_done;
  logic       next_unmapped;
  emi_byte_t  next_rdata;
  logic       cnt_load;
  emi_wait_t  cnt_value;
  logic       cnt_last;
  logic       accept;

  emi_wait_cnt u_wait (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_load  (cnt_load),
    .i_value (cnt_value),
    .o_last  (cnt_last)
  );

  assign accept = i_req && o_ready;

  always_comb begin
    next_state    = state;
    next_bus_addr = bus_addr;
    next_we_q     = we_q;
    next_wdata_q  = wdata_q;
    next_gap_q    = gap_q;
    next_ale      = 1'b0;
    next_rd_n     = 1'b1;
    next_wr_n     = 1'b1;
    next_lo_drive = lo_drive;
    next_lo_val   = lo_val;
    next_done     = 1'b0;
    next_unmapped = 1'b0;
    next_rdata    = o_rdata;
    cnt_load      = 1'b0;
    cnt_value     = req_extra;
    unique case (state)
      EMI_IDLE, EMI_END: begin
        if (accept && req_ext && !ext_mem_enable) begin
          next_unmapped = 1'b1;
          next_done     = 1'b1;
          next_rdata    = 8'h00;
        end else if (accept && req_ext) begin
          next_bus_addr = i_addr;
          next_we_q     = i_we;
          next_wdata_q  = i_wdata;
          next_gap_q    = (req_wait == 2'h3);
          if ((state == EMI_END) && ale && (i_addr == bus_addr)) begin
            // Address already latched by the final-period pulse
            next_state    = EMI_STRB;
            cnt_load      = 1'b1;
            next_rd_n     = i_we;
            next_wr_n     = !i_we;
            next_lo_drive = i_we;
            next_lo_val   = i_wdata;
          end else begin
            next_state    = EMI_ALE;
            next_ale      = 1'b1;
            next_lo_drive = 1'b1;
            next_lo_val   = i_addr[7:0];
          end
        end else begin
          next_state = EMI_IDLE;
        end
      end
      EMI_ALE: begin
        // ALE falls as the low bus changes from address to data
        next_state    = EMI_STRB;
        cnt_load      = 1'b1;
        cnt_value     = (bus_addr >= upper_start) ? ((upper_wait == 2'h0) ? 2'h0 :
                        ((upper_wait == 2'h1) ? 2'h1 : 2'h2)) : ((lower_wait == 2'h0) ? 2'h0 :
                        ((lower_wait == 2'h1) ? 2'h1 : 2'h2));
        next_rd_n     = we_q;
        next_wr_n     = !we_q;
        next_lo_drive = we_q;
        next_lo_val   = wdata_q;
      end
      EMI_STRB: begin
        // ALE held low for the whole strobe
        if (!cnt_last) begin
          next_rd_n = rd_n;
          next_wr_n = wr_n;
        end else begin
          next_done = 1'b1;
          if (!we_q) begin
            next_rdata = i_pa_in;
          end
          if (gap_q) begin
            next_state = EMI_GAP;
          end else begin
            next_state = EMI_END;
            next_ale   = i_next_ram;
            if (i_next_ram) begin
              next_bus_addr = i_next_addr;
              next_lo_drive = 1'b1;
              next_lo_val   = i_next_addr[7:0];
            end
          end
        end
      end
      EMI_GAP: begin
        next_state = EMI_END;
        next_ale   = i_next_ram;
        if (i_next_ram) begin
          next_bus_addr = i_next_addr;
          next_lo_drive = 1'b1;
          next_lo_val   = i_next_addr[7:0];
        end
      end
    endcase
    if (!ext_mem_enable) begin
      next_state    = EMI_IDLE;
      next_ale      = 1'b0;
      next_rd_n     = 1'b1;
      next_wr_n     = 1'b1;
      next_lo_drive = 1'b0;
      cnt_load      = 1'b0;
    end
    next_ready = (next_state == EMI_IDLE) || (next_state == EMI_END);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state      <= EMI_IDLE;
      bus_addr   <= 16'h0000;
      we_q       <= 1'b0;
      wdata_q    <= 8'h00;
      gap_q      <= 1'b0;
      ale        <= 1'b0;
      rd_n       <= 1'b1;
      wr_n       <= 1'b1;
      lo_drive   <= 1'b0;
      lo_val     <= 8'h00;
      o_ready    <= 1'b1;
      o_done     <= 1'b0;
      o_unmapped <= 1'b0;
      o_rdata    <= 8'h00;
    end else begin
      state      <= next_state;
      bus_addr   <= next_bus_addr;
      we_q       <= next_we_q;
      wdata_q    <= next_wdata_q;
      gap_q      <= next_gap_q;
      ale        <= next_ale;
      rd_n       <= next_rd_n;
      wr_n       <= next_wr_n;
      lo_drive   <= next_lo_drive;
      lo_val     <= next_lo_val;
      o_ready    <= next_ready;
      o_done     <= next_done;
      o_unmapped <= next_unmapped;
      o_rdata    <= next_rdata;
    end
  end

  // Pin override
  emi_byte_t next_pa_out;
  emi_byte_t next_pa_oe;
  emi_byte_t next_pc_out;
  emi_byte_t next_pc_oe;
  emi_byte_t next_pd_out;
  emi_byte_t next_pd_oe;
  emi_byte_t next_pe_out;
  emi_byte_t next_pe_oe;

  always_comb begin
    next_pa_out = i_gpio_a_out;
    next_pa_oe  = i_port_a_direction;
    next_pc_out = i_gpio_c_out;
    next_pc_oe  = i_port_c_direction;
    next_pd_out = i_gpio_d_out;
    next_pd_oe  = i_port_d_direction;
    next_pe_out = i_gpio_e_out;
    next_pe_oe  = i_port_e_direction;
    if (next_mcu_control[`EMI_EN_BIT]) begin
      next_pa_out = next_lo_val;
      next_pa_oe  = {8{next_lo_drive}};
      next_pc_out = next_bus_addr[15:8];
      next_pc_oe  = 8'hFF;
      next_pd_out[`EMI_WR_PIN] = next_wr_n;
      next_pd_out[`EMI_RD_PIN] = next_rd_n;
      next_pd_oe[`EMI_WR_PIN]  = 1'b1;
      next_pd_oe[`EMI_RD_PIN]  = 1'b1;
      next_pe_out[`EMI_ALE_PIN] = next_ale;
      next_pe_oe[`EMI_ALE_PIN]  = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_pa_out <= 8'h00;
      o_pa_oe  <= 8'h00;
      o_pc_out <= 8'h00;
      o_pc_oe  <= 8'h00;
      o_pd_out <= 8'h00;
      o_pd_oe  <= 8'h00;
      o_pe_out <= 8'h00;
      o_pe_oe  <= 8'h00;
    end else begin
      o_pa_out <= next_pa_out;
      o_pa_oe  <= next_pa_oe;
      o_pc_out <= next_pc_out;
      o_pc_oe  <= next_pc_oe;
      o_pd_out <= next_pd_out;
      o_pd_oe  <= next_pd_oe;
      o_pe_out <= next_pe_out;
      o_pe_oe  <= next_pe_oe;
    end
  end
endmodule

// >>> emi_top_props.sv
// Checker for the external memory interface pins and register bus
`timescale 1ns/100ps
module emi_top_props (
  input wire logic               i_mclk,
  input wire logic               i_rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [11:0]        paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               o_done,
  input wire logic               o_unmapped,
  input wire emi_pkg::emi_byte_t o_pa_oe,
  input wire emi_pkg::emi_byte_t o_pd_out,
  input wire emi_pkg::emi_byte_t o_pd_oe,
  input wire emi_pkg::emi_byte_t o_pe_out,
  input wire emi_pkg::emi_byte_t o_pe_oe
);
  import emi_pkg::*;
  logic       rd;
  logic       wr;
  logic       ale;
  logic [2:0] slen;
  logic [2:0] next_slen;
  assign rd  = o_pd_oe[7] & ~o_pd_out[7];
  assign wr  = o_pd_oe[6] & ~o_pd_out[6];
  assign ale = o_pe_oe[1] & o_pe_out[1];
  // Length of the current strobe, saturating
  always_comb begin
    next_slen = (rd | wr) ? ((slen == 3'h7) ? slen : slen + 3'h1) : 3'h0;
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      slen <= 3'h0;
    end else begin
      slen <= next_slen;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("register answer late");
  a_err_decode: assert property (pready && paddr != 12'h0D4 && paddr != 12'h0D8 |-> pslverr)
    else $error("unmapped register not refused");
  a_unmapped_done: assert property (o_unmapped |-> o_done && !rd && !wr) else $error("bad refusal");
  a_strobe_len: assert property (slen <= 3'h3) else $error("strobe too long");
  a_strobe_excl: assert property (!(rd && wr)) else $error("both strobes low");
  a_ale_in_xfer: assert property ((rd || wr) |-> !ale) else $error("latch enable during transfer");
  a_ale_addr: assert property (ale |-> o_pa_oe == 8'hFF) else $error("address not driven");
  a_read_release: assert property (rd |-> o_pa_oe == 8'h00) else $error("bus driven in read");
  a_ale_pulse: assert property ($rose(ale) |=> !ale) else $error("latch enable too long");
  c_read: cover property (rd);
  c_write: cover property (wr);
  c_refused: cover property (o_unmapped);
  c_long: cover property (slen == 3'h3);
endmodule

bind emi_top emi_top_props emi_top_props_inst (.i_mclk, .i_rst, .psel, .penable, .paddr, .pready,
  .pslverr, .o_done, .o_unmapped, .o_pa_oe, .o_pd_out, .o_pd_oe, .o_pe_out, .o_pe_oe);

// >>> emi_sram_model.sv
// External SRAM with transparent address latch
`timescale 1ns/100ps
module emi_sram_model (
  input  wire logic               i_mclk,
  input  wire emi_pkg::emi_byte_t i_pa_out,
  input  wire emi_pkg::emi_byte_t i_pc_out,
  input  wire emi_pkg::emi_byte_t i_pd_out,
  input  wire emi_pkg::emi_byte_t i_pd_oe,
  input  wire emi_pkg::emi_byte_t i_pe_out,
  input  wire emi_pkg::emi_byte_t i_pe_oe,
  output emi_pkg::emi_byte_t      o_pa_in
);
  import emi_pkg::*;
  emi_byte_t mem [0:65535];
  emi_byte_t lat;
  logic      rd;
  logic      wr;
  assign rd = i_pd_oe[7] & ~i_pd_out[7];
  assign wr = i_pd_oe[6] & ~i_pd_out[6];
  // Pins taken as they stood through the cycle: ALE falls with the data change
  always_ff @(posedge i_mclk) begin
    if (i_pe_oe[1] & i_pe_out[1]) begin
      lat <= i_pa_out;
    end
    if (wr) begin
      mem[{i_pc_out, lat}] <= i_pa_out;
    end
  end
  // Released bus floats to the pull-up level
  assign o_pa_in = rd ? mem[{i_pc_out, lat}] : 8'hFF;
endmodule

// >>> emi_top_tb.sv
// Self-checking bench for the external memory interface
`timescale 1ns/100ps
`include "emi_defines.svh"
module emi_top_tb;
  import emi_pkg::*;
  localparam logic [11:0] A_MCU = 12'({`EMI_MCU_CTRL_IDX, 2'b00});
  localparam logic [11:0] A_EXT = 12'({`EMI_EXT_CTRL_IDX, 2'b00});
  logic        i_mclk, i_rst, psel, penable, pwrite, pready, pslverr;
  logic        i_req, i_we, o_ready, o_done, o_unmapped;
  logic        i_next_ram;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  emi_addr_t   i_addr, i_next_addr;
  emi_byte_t   i_wdata, o_rdata, i_pa_in, o_pa_out, o_pa_oe, o_pc_out, o_pc_oe;
  emi_byte_t   o_pd_out, o_pd_oe, o_pe_out, o_pe_oe;
  emi_byte_t   gout [4];
  emi_byte_t   gdir [4];
  int          n_fail, total_checks, nale;

  emi_top emi_top_inst (.i_mclk, .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .i_req, .i_we, .i_addr, .i_wdata, .i_next_ram, .i_next_addr, .o_ready,
    .o_done, .o_unmapped, .o_rdata, .i_gpio_a_out(gout[0]), .i_port_a_direction(gdir[0]),
    .i_gpio_c_out(gout[1]), .i_port_c_direction(gdir[1]), .i_gpio_d_out(gout[2]),
    .i_port_d_direction(gdir[2]), .i_gpio_e_out(gout[3]), .i_port_e_direction(gdir[3]), .i_pa_in,
    .o_pa_out, .o_pa_oe, .o_pc_out, .o_pc_oe, .o_pd_out, .o_pd_oe, .o_pe_out, .o_pe_oe);
  emi_sram_model emi_sram_model_inst (.i_pa_out(o_pa_out), .i_pc_out(o_pc_out), .i_pd_out(o_pd_out),
    .i_mclk(i_mclk), .i_pd_oe(o_pd_oe), .i_pe_out(o_pe_out), .i_pe_oe(o_pe_oe), .o_pa_in(i_pa_in));

  initial begin
    i_mclk = 0;
    forever #2 i_mclk = ~i_mclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge i_mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    // Answer taken at the rising edge where pready stands high
    do begin
      @(posedge i_mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task cpu(input logic w, input emi_addr_t a, input emi_byte_t d, output int len, output emi_byte_t q,
    output logic um);
    @(posedge i_mclk);
    i_req   <= 1'b1;
    i_we    <= w;
    i_addr  <= a;
    i_wdata <= d;
    do begin
      @(posedge i_mclk);
    end while (o_ready !== 1'b1);
    i_req <= 1'b0;
    len  = 0;
    nale = 0;
    do begin
      @(posedge i_mclk);
      if (o_pd_oe[7:6] == 2'b11 && o_pd_out[7:6] != 2'b11) len++;
      if (o_pe_oe[1] && o_pe_out[1]) nale++;
    end while (o_done !== 1'b1);
    q  = o_rdata;
    um = o_unmapped;
  endtask

  task t_regs;
    logic [31:0] q;
    logic e;
    apb(0, A_MCU, 0, q, e);
    chk(q, 32'h0, "control reset");
    apb(0, A_EXT, 0, q, e);
    chk(q, 32'h0, "extended reset");
    apb(1, A_EXT, 32'hFFFFFFFF, q, e);
    apb(0, A_EXT, 0, q, e);
    chk(q, 32'hFF, "extended readback");
    apb(0, 12'h0DC, 0, q, e);
    chk({q[30:0], e}, 32'h1, "unmapped register");
    apb(1, A_EXT, 0, q, e);
    $display("t_regs done");
  endtask

  task t_disabled;
    logic [31:0] q;
    logic e, um;
    int len;
    emi_byte_t d;
    apb(1, A_MCU, 32'h80, q, e);
    apb(1, A_MCU, 32'h00, q, e);
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({o_pa_out, o_pa_oe, o_pd_out, o_pd_oe}, {gout[0], gdir[0], gout[2], gdir[2]}, "pins restored");
    cpu(0, 16'h1000, 0, len, d, um);
    chk({um, 31'(len)}, 32'h80000000, "disabled access");
    $display("t_disabled done");
  endtask

  task t_enable;
    logic [31:0] q;
    logic e;
    gdir <= '{8'h00, 8'h00, 8'h00, 8'h00};
    apb(1, A_MCU, 32'h80, q, e);
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({o_pc_oe, o_pd_oe[7:6], o_pd_out[7:6], o_pe_oe[1]}, 32'h1FFF, "override");
    $display("t_enable done");
  endtask

  task t_pages;
    logic [31:0] q;
    logic e, um;
    logic [1:0] lw, uw;
    int len;
    emi_byte_t d, rdv;
    emi_addr_t top, a;
    for (int c = 0; c < 2; c++) begin
      lw = c ? 2'd0 : 2'd1;
      uw = c ? 2'd3 : 2'd2;
      for (int lim = 0; lim < 8; lim++) begin
        apb(1, A_EXT, {25'h0, 3'(lim), lw, uw[1], 1'b0}, q, e);
        apb(1, A_MCU, {24'h0, 1'b1, uw[0], 6'h0}, q, e);
        top = lim ? {3'(lim), 13'h0} : 16'h0460;
        for (int k = 0; k < 2; k++) begin
          if (k == 0 || lim != 0) begin
            a = k ? top - 16'h1 : top;
            d = 8'(8'h40 + 2 * lim + k);
            cpu(1, a, d, len, rdv, um);
            chk(32'(len), (k ? lw : uw) == 0 ? 1 : (k ? lw : uw) == 1 ? 2 : 3, "write wait");
            cpu(0, a, 8'h00, len, rdv, um);
            chk(32'(len), (k ? lw : uw) == 0 ? 1 : (k ? lw : uw) == 1 ? 2 : 3, "read wait");
            chk({rdv, 24'(nale)}, {d, 24'h1}, "read data");
          end
        end
      end
    end
    $display("t_pages done");
  endtask

  task t_next;
    logic [31:0] q;
    logic e, um;
    int len, takes, dones, cyc;
    emi_byte_t d;
    apb(1, A_EXT, 0, q, e);
    apb(1, A_MCU, 32'h80, q, e);
    cpu(1, 16'h2345, 8'h5A, len, d, um);
    // Read request held through the final period of the first read
    i_next_ram  <= 1'b1;
    i_next_addr <= 16'h2345;
    i_req       <= 1'b1;
    i_we        <= 1'b0;
    i_addr      <= 16'h2345;
    takes = 0;
    dones = 0;
    cyc   = 0;
    nale  = 0;
    len   = 0;
    d     = 8'h00;
    do begin
      @(posedge i_mclk);
      if (takes > 0) cyc++;
      if (o_pd_oe[7] && !o_pd_out[7]) len++;
      if (o_pe_oe[1] && o_pe_out[1]) begin
        nale++;
        chk({16'h0, o_pc_out, o_pa_out}, 32'h2345, "address at latch enable");
      end
      if (o_done === 1'b1) begin
        dones++;
        d = o_rdata;
      end
      if (i_req && o_ready) begin
        takes++;
        if (takes == 2) i_req <= 1'b0;
      end
    end while (dones < 2);
    i_next_ram <= 1'b0;
    chk(32'(cyc), 32'd5, "preloaded access time");
    chk({d, 8'(nale), 8'(len), 8'h00}, {8'h5A, 8'h03, 8'h02, 8'h00}, "final period pulse");
    $display("t_next done");
  endtask

  initial begin
    i_rst        = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0000_0000;
    i_req        = 1'b0;
    i_we         = 1'b0;
    i_addr       = 16'h0000;
    i_wdata      = 8'h00;
    i_next_ram   = 1'b0;
    i_next_addr  = 16'h0000;
    n_fail       = 0;
    total_checks = 0;
    gout = '{8'h12, 8'h34, 8'hC5, 8'h0D};
    gdir = '{8'hF0, 8'h0F, 8'hFF, 8'hFF};
    repeat (10) @(posedge i_mclk);
    i_rst <= 0;
    t_regs;
    t_disabled;
    t_enable;
    t_pages;
    t_next;
    test_done;
  end

  initial begin
    #100000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end
endmodule
